// >>> verilog/cfg_pkg.sv
/*
 * shared constants, config layout and divider decoding for the divider
 * configuration block and the host that drives its pins.
 * assumes one 250 MHz clock (hclk) on both ends.
 */
// How it works
// R1 - pre-select 0 divides by two, 1 by four
// R2 - output code 000..101 divides by 2..64
// R3 - halving select halves second output when set
// R4 - host keeps feedback inside range for pre-divider
// R5 - host keeps loop frequency within 1360..2720
// R6 - output equals ref/pre times feedback/output-divide
// R7 - feedback step moves output by ref/(pre*out)
// R8 - fifteen parallel pins carry the whole setting
// R9 - parallel path live only while mode pin low
// R10 - pin changes apply at once, no strobe
// R11 - parallel mode blocks serial writes, allows reads
// R12 - reset release captures pins regardless of mode
// R13 - open pins load built-in default setting
// R14 - host presents valid setting at reset release
// R15 - mode pin high: pins ignored, serial opens
// R16 - pins are write-only, no readback path; code reads them back via cfg_low/cfg_high after capture or OP_GET
// R17 - default is 500, code 011, halving 0, pre 1
// R18 - mode pin high allows serial reads and writes
// R19 - host never flips mode during serial access
// R20 - host never drives output codes 110/111
// R21 - pins resynchronised before being applied
package cfg_pkg;

    typedef struct packed {
        logic       pre_sel;
        logic [9:0] feedback;
        logic [2:0] out_code;
        logic       halving;
    } div_cfg_s;

    localparam int unsigned CFG_BITS = 15;

    // register byte offsets on the ahb slave
    localparam logic [7:0] ADDR_CFG_LOW  = 8'h00;
    localparam logic [7:0] ADDR_CFG_HIGH = 8'h04;
    localparam logic [7:0] ADDR_CMD      = 8'h08;
    localparam logic [7:0] ADDR_STATUS   = 8'h0c;

    // cfg_high field positions
    localparam int unsigned HIGH_FB_LSB   = 6;
    localparam int unsigned HIGH_CODE_LSB = 3;
    localparam int unsigned HIGH_HALV_BIT = 2;
    localparam int unsigned HIGH_PRE_BIT  = 1;

    // command opcodes written to the cmd register
    localparam logic [7:0] OP_LOAD = 8'h01;
    localparam logic [7:0] OP_GET  = 8'h02;
    localparam logic [7:0] OP_INC  = 8'h03;
    localparam logic [7:0] OP_DEC  = 8'h04;

    // startup setting used when the pins float
    localparam div_cfg_s DEFAULT_CFG = '{pre_sel: 1'b1, feedback: 10'h1f4,
                                         out_code: 3'h3, halving: 1'b0}; // see R17

    // loop limits the host must respect
    localparam int unsigned FB_MIN_P2 = 170;
    localparam int unsigned FB_MAX_P2 = 340;
    localparam int unsigned FB_MIN_P4 = 340;
    localparam int unsigned FB_MAX_P4 = 680;
    localparam int unsigned VCO_MIN_MHZ = 1360;
    localparam int unsigned VCO_MAX_MHZ = 2720;
    localparam logic [2:0]  CODE_MAX    = 3'h5;

    // least low time of the mode pin
    localparam int unsigned CLK_PERIOD_PS = 4000;
    localparam int unsigned MODE_MIN_NS   = 50;
    localparam int unsigned MODE_MIN_CYC  = (MODE_MIN_NS * 1000 + CLK_PERIOD_PS - 1)
                                            / CLK_PERIOD_PS;

    function automatic logic [2:0] pre_ratio(input logic sel);
        return sel ? 3'h4 : 3'h2; // see R1
    endfunction

    function automatic logic [6:0] out_ratio(input logic [2:0] code);
        return 7'h02 << code; // see R2
    endfunction

    function automatic logic [7:0] pack_low(input div_cfg_s c);
        return c.feedback[7:0];
    endfunction

    function automatic logic [7:1] pack_high(input div_cfg_s c);
        return {c.feedback[9:8], c.out_code, c.halving, c.pre_sel};
    endfunction

    function automatic div_cfg_s unpack(input logic [7:0] lo, input logic [7:1] hi);
        return '{pre_sel: hi[HIGH_PRE_BIT], feedback: {hi[7:6], lo},
                 out_code: hi[5:3], halving: hi[HIGH_HALV_BIT]};
    endfunction

endpackage

// >>> verilog/cfg_link.sv
/*
 * parallel configuration pins between host and divider block.
 * assumes both ends run on the same hclk; no wire resolution needed,
 * the device itself substitutes the default when pins_oe is low.
 */
`timescale 1ns/1ps
interface cfg_link;
    logic               master_reset_n;
    logic               parallel_mode_n;
    cfg_pkg::div_cfg_s  pins;
    logic               pins_oe;

    modport host
    (
        output master_reset_n,
        output parallel_mode_n,
        output pins,
        output pins_oe
    );

    modport device
    (
        input  master_reset_n,
        input  parallel_mode_n,
        input  pins,
        input  pins_oe
    );
endinterface

// >>> verilog/phase_synth.sv
/*
 * phase accumulator standing in for the loop and post dividers.
 * assumes hclk is the scaled reference: first output runs at
 * f_hclk * feedback / (pre * out * PHASE_SCALE).
 */
`timescale 1ns/1ps
module phase_synth #(
    parameter int unsigned PHASE_SCALE = 1024
)(
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic              run,
    input  cfg_pkg::div_cfg_s      cfg,
    output logic                   first_clock_out,
    output logic                   second_clock_out
);
    logic [21:0] modulus;
    logic [21:0] acc;
    logic [21:0] sum;
    logic [21:0] next_acc;
    logic        next_first;

    // one wrap of the accumulator is one output period
    always_comb
    begin
        modulus = 22'(cfg_pkg::pre_ratio(cfg.pre_sel)) * 22'(cfg_pkg::out_ratio(cfg.out_code))
                  * 22'(PHASE_SCALE); // see R6
        sum = acc + 22'(cfg.feedback); // see R7
        next_acc = (sum >= modulus) ? sum - modulus : sum;
        next_first = (next_acc >= (modulus >> 1));
    end

    // phase and first output; stopped outputs sit low
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            acc <= 22'h0;
            first_clock_out <= 1'b0;
        end
        else
        begin
            acc <= run ? next_acc : 22'h0;
            first_clock_out <= run & next_first;
        end
    end

    // second output copies first or toggles on its rising edge
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            second_clock_out <= 1'b0;
        else if (!run)
            second_clock_out <= 1'b0;
        else if (!cfg.halving)
            second_clock_out <= next_first; // see R3
        else if (next_first && !first_clock_out)
            second_clock_out <= ~second_clock_out; // see R3
    end
endmodule

// >>> verilog/synth_divider_config.sv
/*
 * divider configuration block: parallel pin path, startup capture and
 * an ahb-lite register slave standing for the serial register path.
 * assumes a single ahb-lite master with this slave alone on the bus,
 * and link pins that may change at any time relative to hclk.
 */
// Implementation choices: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps
module synth_divider_config #(
    parameter int unsigned PHASE_SCALE = 1024
)(
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic                   hreadyout,
    output logic [31:0]            hrdata,
    output logic                   hresp,
    cfg_link.device                link,
    output cfg_pkg::div_cfg_s      applied_cfg,
    output logic                   parallel_active,
    output logic                   started,
    output logic                   first_clock_out,
    output logic                   second_clock_out
);
    localparam int unsigned SYNC_W = cfg_pkg::CFG_BITS + 3;
    // mode pin idles high (serial), everything else low
    localparam logic [SYNC_W-1:0] SYNC_INIT = {2'b01, {(SYNC_W-2){1'b0}}};

    logic [SYNC_W-1:0]  sync1;
    logic [SYNC_W-1:0]  sync2;
    logic [SYNC_W-1:0]  sync3;
    logic [SYNC_W-1:0]  settled;
    logic               st_mr_n;
    logic               st_mode_n;
    logic               st_oe;
    cfg_pkg::div_cfg_s  st_pins;
    cfg_pkg::div_cfg_s  pin_cfg;
    logic               mr_prev;
    logic               mr_rise;
    logic               par_mode;

    logic               take;
    logic               wr_pend;
    logic [7:0]         wr_addr;
    logic               wr_ok;
    logic [7:0]         cfg_low;
    logic [7:1]         cfg_high;
    logic [31:0]        next_rdata;
    cfg_pkg::div_cfg_s  reg_cfg;

    // pins cross into hclk; the first stage feeds only the second
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            sync1 <= SYNC_INIT;
            sync2 <= SYNC_INIT;
            sync3 <= SYNC_INIT;
        end
        else
        begin
            sync1 <= {link.master_reset_n, link.parallel_mode_n, link.pins_oe, link.pins};
            sync2 <= sync1; // see R21
            sync3 <= sync2;
        end
    end

    // a bus is taken only after two equal samples, so a skewed
    // multi-bit change never reaches the dividers half-applied
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            settled <= SYNC_INIT;
        else if (sync2 == sync3)
            settled <= sync3; // see R21
    end

    assign st_mr_n   = settled[SYNC_W-1];
    assign st_mode_n = settled[SYNC_W-2];
    assign st_oe     = settled[SYNC_W-3];
    assign st_pins   = cfg_pkg::div_cfg_s'(settled[cfg_pkg::CFG_BITS-1:0]); // see R8

    // undriven pins fall back to the built-in setting
    assign pin_cfg  = st_oe ? st_pins : cfg_pkg::DEFAULT_CFG; // see R13
    assign par_mode = ~st_mode_n; // see R9
    assign mr_rise  = st_mr_n & ~mr_prev;

    // reset release edge and mode flags
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            mr_prev <= 1'b0;
            started <= 1'b0;
            parallel_active <= 1'b0;
        end
        else
        begin
            mr_prev <= st_mr_n;
            started <= st_mr_n & (started | mr_rise);
            parallel_active <= par_mode;
        end
    end

    // ahb address phase: zero wait states, always okay
    assign take  = hsel & htrans[1] & hready;
    assign wr_ok = wr_pend & ~par_mode; // see R11
    assign reg_cfg = cfg_pkg::unpack(cfg_low, cfg_high);

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
        else
        begin
            wr_pend <= take & hwrite;
            wr_addr <= haddr[7:0];
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // read mux; unmapped words and the cmd register read zero
    always_comb
    begin
        next_rdata = 32'h0;
        if (haddr[31:8] == 24'h0)
        begin
            unique case (haddr[7:0])
                cfg_pkg::ADDR_CFG_LOW:  next_rdata = {24'h0, cfg_low};
                cfg_pkg::ADDR_CFG_HIGH: next_rdata = {24'h0, cfg_high, 1'b0};
                cfg_pkg::ADDR_STATUS:   next_rdata = {30'h0, started, parallel_active};
                default:                next_rdata = 32'h0;
            endcase
        end
    end

    // reads stay open in both modes
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata <= 32'h0;
        else if (take && !hwrite)
            hrdata <= next_rdata; // see R18
    end

    // serial copy of the setting; startup capture mirrors the pins here
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cfg_low <= cfg_pkg::pack_low(cfg_pkg::DEFAULT_CFG);
            cfg_high <= cfg_pkg::pack_high(cfg_pkg::DEFAULT_CFG);
        end
        else if (mr_rise)
        begin
            cfg_low <= cfg_pkg::pack_low(pin_cfg); // see R12
            cfg_high <= cfg_pkg::pack_high(pin_cfg);
        end
        else if (wr_ok)
        begin
            unique case (wr_addr)
                cfg_pkg::ADDR_CFG_LOW:  cfg_low <= hwdata[7:0]; // see R18
                cfg_pkg::ADDR_CFG_HIGH: cfg_high <= hwdata[7:1]; // see R18
                cfg_pkg::ADDR_CMD:
                begin
                    if (hwdata[7:0] == cfg_pkg::OP_GET)
                    begin
                        cfg_low <= cfg_pkg::pack_low(applied_cfg);
                        cfg_high <= cfg_pkg::pack_high(applied_cfg);
                    end
                end
                default:
                begin
                end
            endcase
        end
    end

    // applied dividers: startup capture, then live pins, then commands.
    // the pins reach a read path only through cfg_low/cfg_high, by the startup capture or by OP_GET of pin-set applied_cfg; see R16
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            applied_cfg <= cfg_pkg::DEFAULT_CFG;
        else if (mr_rise)
            applied_cfg <= pin_cfg; // see R12
        else if (par_mode && st_mr_n)
            applied_cfg <= pin_cfg; // see R10
        else if (wr_ok && wr_addr == cfg_pkg::ADDR_CMD) // see R15
        begin
            // inc and dec do not check loop limits
            unique case (hwdata[7:0])
                cfg_pkg::OP_LOAD: applied_cfg <= reg_cfg;
                cfg_pkg::OP_INC:  applied_cfg.feedback <= applied_cfg.feedback + 10'h1;
                cfg_pkg::OP_DEC:  applied_cfg.feedback <= applied_cfg.feedback - 10'h1;
                default:
                begin
                end
            endcase
        end
    end

    // clock outputs run only after a startup capture
    phase_synth #(
        .PHASE_SCALE (PHASE_SCALE)
    ) u_synth (
        .hclk             (hclk),
        .hresetn          (hresetn),
        .run              (started),
        .cfg              (applied_cfg),
        .first_clock_out  (first_clock_out),
        .second_clock_out (second_clock_out)
    );
endmodule

// >>> verilog/host_cfg_driver.sv
/*
 * host end of the parallel pins: checks and drives a setting, runs
 * the mode pin and the master reset of the divider block.
 * assumes user requests are synchronous one-cycle pulses on hclk.
 */
`timescale 1ns/1ps
module host_cfg_driver #(
    parameter int unsigned REF_MHZ    = 16,
    parameter int unsigned RESET_HOLD = 16
)(
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic              apply,
    input  cfg_pkg::div_cfg_s      req_cfg,
    input  wire logic              want_parallel,
    input  wire logic              serial_busy,
    input  wire logic              restart,
    input  wire logic              float_pins,
    output logic                   rejected,
    output logic                   in_reset,
    cfg_link.host                  link
);
    logic [15:0] rst_cnt;
    logic [15:0] low_cnt;
    logic        req_ok;

    // setting must suit the loop before it reaches the pins
    function automatic logic cfg_valid(input cfg_pkg::div_cfg_s c);
        int unsigned fb;
        int unsigned vco_x_p;
        logic        fb_ok;
        fb = 32'(c.feedback);
        vco_x_p = REF_MHZ * fb;
        fb_ok = c.pre_sel ? (fb >= cfg_pkg::FB_MIN_P4 && fb <= cfg_pkg::FB_MAX_P4)
                          : (fb >= cfg_pkg::FB_MIN_P2 && fb <= cfg_pkg::FB_MAX_P2); // see R4
        return fb_ok && c.out_code <= cfg_pkg::CODE_MAX // see R20
            && vco_x_p >= cfg_pkg::VCO_MIN_MHZ * 32'(cfg_pkg::pre_ratio(c.pre_sel)) // see R5
            && vco_x_p <= cfg_pkg::VCO_MAX_MHZ * 32'(cfg_pkg::pre_ratio(c.pre_sel));
    endfunction

    assign req_ok = cfg_valid(req_cfg);

    // pins hold the last accepted setting, also across reset release
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            link.pins <= cfg_pkg::DEFAULT_CFG;
            link.pins_oe <= 1'b0;
            rejected <= 1'b0;
        end
        else
        begin
            link.pins_oe <= ~float_pins;
            if (apply)
            begin
                rejected <= ~req_ok;
                if (req_ok)
                    link.pins <= req_cfg; // see R14
            end
        end
    end

    // master reset low for RESET_HOLD+1 cycles after power-up or restart
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rst_cnt <= 16'(RESET_HOLD);
            link.master_reset_n <= 1'b0;
            in_reset <= 1'b1;
        end
        else if (restart)
        begin
            rst_cnt <= 16'(RESET_HOLD);
            link.master_reset_n <= 1'b0;
            in_reset <= 1'b1;
        end
        else
        begin
            rst_cnt <= (rst_cnt != 16'h0) ? rst_cnt - 16'h1 : 16'h0;
            link.master_reset_n <= (rst_cnt == 16'h0);
            in_reset <= (rst_cnt != 16'h0);
        end
    end

    // mode pin: moves only while no serial access runs, and once low
    // stays low for the least pulse width
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            link.parallel_mode_n <= 1'b1;
            low_cnt <= 16'h0;
        end
        else if (serial_busy)
            low_cnt <= (low_cnt != 16'h0) ? low_cnt - 16'h1 : 16'h0; // see R19
        else if (want_parallel && link.parallel_mode_n)
        begin
            link.parallel_mode_n <= 1'b0; // see R9
            low_cnt <= 16'(cfg_pkg::MODE_MIN_CYC);
        end
        else if (!want_parallel && !link.parallel_mode_n && low_cnt == 16'h0)
            link.parallel_mode_n <= 1'b1;
        else
            low_cnt <= (low_cnt != 16'h0) ? low_cnt - 16'h1 : 16'h0;
    end
endmodule

// >>> sim/cfg_sva.sv
/*
 * assertions on the parallel link and the divider block outputs.
 * assumes one hclk domain; the testbench instantiates it beside the link.
 */
`timescale 1ns/1ps
module cfg_sva (
    input wire logic              hclk,
    input wire logic              hresetn,
    input wire logic              hsel,
    input wire logic [1:0]        htrans,
    input wire logic              hwrite,
    input wire logic              hreadyout,
    input wire logic              hresp,
    input wire logic              master_reset_n,
    input wire logic              parallel_mode_n,
    input cfg_pkg::div_cfg_s      pins,
    input wire logic              pins_oe,
    input cfg_pkg::div_cfg_s      applied_cfg,
    input wire logic              parallel_active,
    input wire logic              started,
    input wire logic              first_clock_out,
    input wire logic              second_clock_out
);
    logic [3:0] par_cnt;
    logic [3:0] ser_cnt;
    localparam cfg_pkg::div_cfg_s BOOT_CFG = cfg_pkg::DEFAULT_CFG;

    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // pins steady in live parallel mode; eight cycles outlast the resync chain
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn)
            par_cnt <= 4'h0;
        else if (!parallel_mode_n && master_reset_n && pins_oe && $stable(pins))
            par_cnt <= (par_cnt == 4'hf) ? par_cnt : par_cnt + 4'h1;
        else
            par_cnt <= 4'h0;

    // serial mode with no bus write; only a write may move the dividers then
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn)
            ser_cnt <= 4'h0;
        else if (parallel_mode_n && master_reset_n && !(hsel && htrans[1] && hwrite))
            ser_cnt <= (ser_cnt == 4'hf) ? ser_cnt : ser_cnt + 4'h1;
        else
            ser_cnt <= 4'h0;

    okay_resp_a: assert property (hreadyout && !hresp)
        else $error("bus answer not ready or not okay");
    par_follow_a: assert property (par_cnt == 4'h8 |-> applied_cfg == pins)
        else $error("dividers do not follow steady pins");
    ser_hold_a: assert property (ser_cnt >= 4'h8 |-> $stable(applied_cfg))
        else $error("dividers moved in serial mode without a write");
    default_boot_a: assert property ($rose(hresetn) |-> applied_cfg == BOOT_CFG)
        else $error("dividers not at default after reset");
    mode_gate_a: assert property ($rose(parallel_active) |-> !parallel_mode_n)
        else $error("parallel mode seen while mode pin high");
    mode_width_a: assert property ($fell(parallel_mode_n) |-> (!parallel_mode_n)[*8])
        else $error("mode pin low pulse too short");
    boot_capture_a: assert property ($rose(started) |-> ##[0:1]
        applied_cfg == (pins_oe ? pins : BOOT_CFG))
        else $error("startup capture wrong");
    start_delay_a: assert property ($rose(master_reset_n) |-> ##[1:8] started)
        else $error("start not seen after master reset release");
    stop_delay_a: assert property ($fell(master_reset_n) |-> ##[1:6] !started)
        else $error("start flag kept through master reset");
    clocks_idle_a: assert property (!started && !$past(started) |->
        !first_clock_out && !second_clock_out)
        else $error("output clocks run before start");

    cover property ($rose(parallel_active));
    cover property ($rose(started));
    cover property (par_cnt == 4'h8);
endmodule

// >>> sim/testbench.sv
/*
 * testbench: host driver and divider block joined by the link, ahb-lite
 * master tasks and directed scenarios. assumes 250 MHz hclk, no random.
 */
`timescale 1ns/1ps
module testbench;
    logic              hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0]       haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic [1:0]        htrans = 2'h0;
    logic [2:0]        hsize = 3'h2;
    logic              hready, hresp, parallel_active, started, fclk, sclk;
    logic              apply = 1'b0, want_parallel = 1'b0, serial_busy = 1'b0;
    logic              restart = 1'b0, float_pins = 1'b1, rejected, in_reset;
    cfg_pkg::div_cfg_s applied_cfg, e, req_cfg = 15'h0;
    int                errors = 0, checked = 0;
    localparam cfg_pkg::div_cfg_s CFG_D = '{1'b1, 10'h1f4, 3'h3, 1'b0};
    localparam cfg_pkg::div_cfg_s CFG_B = '{1'b0, 10'h0fa, 3'h2, 1'b1};
    localparam cfg_pkg::div_cfg_s CFG_C = '{1'b1, 10'h190, 3'h1, 1'b0};
    localparam cfg_pkg::div_cfg_s CFG_E = '{1'b1, 10'h1f4, 3'h5, 1'b1};
    always #2 hclk = ~hclk;
    cfg_link link_if();
    synth_divider_config #(.PHASE_SCALE(64)) synth_divider_config_inst (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hready), .hrdata(hrdata), .hresp(hresp), .link(link_if),
        .applied_cfg(applied_cfg), .parallel_active(parallel_active), .started(started),
        .first_clock_out(fclk), .second_clock_out(sclk));
    host_cfg_driver #(.REF_MHZ(16), .RESET_HOLD(16)) host_cfg_driver_inst (
        .hclk(hclk), .hresetn(hresetn), .apply(apply), .req_cfg(req_cfg),
        .want_parallel(want_parallel), .serial_busy(serial_busy), .restart(restart),
        .float_pins(float_pins), .rejected(rejected), .in_reset(in_reset), .link(link_if));
    cfg_sva cfg_sva_inst (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
        .hreadyout(hready), .hresp(hresp), .master_reset_n(link_if.master_reset_n),
        .parallel_mode_n(link_if.parallel_mode_n), .pins(link_if.pins),
        .pins_oe(link_if.pins_oe), .applied_cfg(applied_cfg),
        .parallel_active(parallel_active), .started(started),
        .first_clock_out(fclk), .second_clock_out(sclk));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out;
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // one bus phase, bounded
    task automatic wait_ready;
        int n;
        n = 0;
        @(posedge hclk);
        while (hready !== 1'b1 && n < 50)
        begin
            @(posedge hclk);
            n++;
        end
        if (n >= 50)
        begin
            errors++;
            close_out();
        end
    endtask

    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= wr;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        wait_ready();
        q = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        ahb(1'b1, a, d, q);
    endtask

    task automatic rd_check(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        ahb(1'b0, a, 32'h0, q);
        check(q, exp);
    endtask

    // bounded wait, then one compare
    task automatic wait_cfg(input cfg_pkg::div_cfg_s x);
        int n;
        n = 0;
        while (applied_cfg !== x && n < 20)
        begin
            @(posedge hclk);
            n++;
        end
        check({17'h0, applied_cfg}, {17'h0, x});
    endtask

    task automatic wait_started(input logic v);
        int n;
        n = 0;
        while (started !== v && n < 200)
        begin
            @(posedge hclk);
            n++;
        end
        check({31'h0, started}, {31'h0, v});
    endtask

    task automatic host_apply(input cfg_pkg::div_cfg_s x);
        req_cfg <= x;
        apply <= 1'b1;
        @(posedge hclk);
        apply <= 1'b0;
        @(posedge hclk);
    endtask

    // rising edges of both outputs, two edges of slack
    task automatic measure(input int e1, input int e2);
        int n1, n2;
        logic p1, p2;
        n1 = 0;
        n2 = 0;
        p1 = fclk;
        p2 = sclk;
        repeat (4096)
        begin
            @(posedge hclk);
            n1 += (fclk && !p1) ? 1 : 0;
            n2 += (sclk && !p2) ? 1 : 0;
            p1 = fclk;
            p2 = sclk;
        end
        check({31'h0, n1 >= e1 - 2 && n1 <= e1 + 2}, 32'h1);
        check({31'h0, n2 >= e2 - 2 && n2 <= e2 + 2}, 32'h1);
    endtask

    function automatic logic [31:0] hi(input cfg_pkg::div_cfg_s c);
        return {24'h0, c.feedback[9:8], c.out_code, c.halving, c.pre_sel, 1'b0};
    endfunction

    initial
    begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        wait_started(1'b1);
        wait_cfg(CFG_D);
        rd_check(8'h00, 32'hf4);
        rd_check(8'h04, hi(CFG_D));
        rd_check(8'h0c, 32'h2);
        measure(500, 500);
        // serial path: registers, load, step and readback
        wr(8'h00, {24'h0, CFG_B.feedback[7:0]});
        wr(8'h04, hi(CFG_B));
        wr(8'h08, 32'h1);
        wait_cfg(CFG_B);
        measure(1000, 500);
        wr(8'h08, 32'h3);
        e = CFG_B;
        e.feedback = 10'h0fb;
        wait_cfg(e);
        wr(8'h08, 32'h2);
        rd_check(8'h00, 32'hfb);
        wr(8'h08, 32'h4);
        wait_cfg(CFG_B);
        rd_check(8'h10, 32'h0);
        // pins ignored while mode pin high
        float_pins <= 1'b0;
        host_apply(CFG_C);
        check({31'h0, rejected}, 32'h0);
        repeat (10) @(posedge hclk);
        check({17'h0, applied_cfg}, {17'h0, CFG_B});
        // a busy serial bus holds the mode pin
        want_parallel <= 1'b1;
        serial_busy <= 1'b1;
        repeat (10) @(posedge hclk);
        check({31'h0, link_if.parallel_mode_n}, 32'h1);
        serial_busy <= 1'b0;
        wait_cfg(CFG_C);
        rd_check(8'h0c, 32'h3);
        wr(8'h00, 32'h55);
        wr(8'h08, 32'h1);
        repeat (10) @(posedge hclk);
        check({17'h0, applied_cfg}, {17'h0, CFG_C});
        rd_check(8'h00, 32'hfb);
        host_apply('{1'b0, 10'd100, 3'h2, 1'b0});
        check({31'h0, rejected}, 32'h1);
        host_apply('{1'b1, 10'd400, 3'h6, 1'b0});
        check({31'h0, rejected}, 32'h1);
        // output codes 000..101 through the pins
        for (int k = 0; k < 6; k++)
        begin
            e = '{1'b0, 10'd200, 3'(k), 1'(k)};
            host_apply(e);
            wait_cfg(e);
        end
        // master reset captures the pins with the mode pin high
        want_parallel <= 1'b0;
        repeat (20) @(posedge hclk);
        host_apply(CFG_E);
        restart <= 1'b1;
        @(posedge hclk);
        restart <= 1'b0;
        wait_started(1'b0);
        check({31'h0, in_reset}, 32'h1);
        wait_started(1'b1);
        wait_cfg(CFG_E);
        measure(125, 62);
        rd_check(8'h00, 32'hf4);
        close_out();
    end
endmodule
